// [hw/sdc_core.sv]
// SDRAM command decoder, burst engine, write buffer and array
// What this block does
// - All pins are sampled, and read data launched, on the rising clock edge.
// - Bursts of 4 or 8 words; device steps the column itself.
// - After a read burst ends the data outputs float until the next read.
// - First read word two cycles after the read command, rest back to back.
// - First write word is taken on the write command's own edge.
// - Alternating bank commands give gapless data at clock rate.
// - Precharge with bit 10 low closes one bank, bit 10 high both.
// - Bit 10 high on read or write closes the bank after the burst.
// - Chip select high mutes ras, cas and we; select edge takes a command.
// - Deselecting never disturbs a burst already running.
// - Lower gate covers the even bytes, upper gate the odd bytes.
// - A gate high in a write cycle discards that byte, no latency.
// - Clock enable low freezes the data bus at the second edge after it falls.
// - Suspended work resumes on the second edge after clock enable rises.
// - With mode bit 9 zero writes use the programmed burst length.
// - An invalid mode word leaves the mode register unchanged.
// - Read, write, stop and no-op codes; bit 10 asks for auto close.
// - Bank bit high selects the first bank, low the second.
// - Auto refresh steps an internal row counter of 4096 rows.
// - Burst columns count up and wrap inside their aligned block.
`default_nettype none

// ----------------------------------------
// Write buffer
// ----------------------------------------
module sdc_fifo #(
    parameter int W = 8,
    parameter int DEPTH = sdc_pkg::BUF_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    import sdc_pkg::*;

    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } sdc_fifo_state_t;

    sdc_fifo_state_t s;
    sdc_fifo_state_t n;
    logic [W-1:0] mem [DEPTH];
    logic push;
    logic pop;

    function automatic logic [PW-1:0] inc_ptr(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction: inc_ptr

    assign in_ready = s.cnt != (PW + 1)'(DEPTH);
    assign out_valid = s.cnt != '0;
    assign out_data = mem[s.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        n = s;
        if (push) begin
            n.wp = inc_ptr(s.wp);
        end
        if (pop) begin
            n.rp = inc_ptr(s.rp);
        end
        n.cnt = s.cnt + (PW + 1)'(push) - (PW + 1)'(pop);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[s.wp] <= in_data;
        end
    end

endmodule: sdc_fifo

// ----------------------------------------
// Device top
// ----------------------------------------
module sdc_core #(
    parameter int DQ_W = sdc_pkg::DQ_W,
    parameter int ROW_W = sdc_pkg::ROW_W,
    parameter int COL_W = sdc_pkg::COL_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [sdc_pkg::ADDR_W-1:0] addr,
    input wire logic lower_byte_gate,
    input wire logic upper_byte_gate,
    input wire logic [DQ_W-1:0] dq_in,
    output logic [DQ_W-1:0] dq_out,
    output logic dq_oe,
    output logic [1:0] bank_open,
    output logic [sdc_pkg::REF_W-1:0] refresh_row,
    output logic write_room
);
    import sdc_pkg::*;

    localparam int LANES = DQ_W / 8;
    localparam int MA_W = 1 + ROW_W + COL_W;
    localparam int FW = MA_W + DQ_W + LANES;

    typedef struct packed {
        logic cke_q;
        logic [1:0] open;
        logic [1:0][ROW_W-1:0] row;
        logic len8;
        logic wr_single;
        logic rd_act;
        logic rd_bank;
        logic [COL_W-1:0] rd_col;
        logic [2:0] rd_cnt;
        logic rd_close;
        logic wr_act;
        logic wr_bank;
        logic [COL_W-1:0] wr_col;
        logic [2:0] wr_cnt;
        logic wr_close;
        logic [DQ_W-1:0] dq;
        logic oe;
        logic [REF_W-1:0] ref_row;
        logic room;
    } sdc_state_t;

    sdc_state_t s;
    sdc_state_t n;
    logic [DQ_W-1:0] array [2 ** MA_W];
    logic hold;
    logic cmd_ok;
    logic [2:0] cmd;
    logic bank_idx;
    logic mode_ok;
    logic rd_go;
    logic wr_go;
    logic act_go;
    logic pre_go;
    logic ref_go;
    logic mode_go;
    logic push_v;
    logic push_bank;
    logic [COL_W-1:0] push_col;
    logic [LANES-1:0] push_keep;
    logic [DQ_W-1:0] rd_word;
    logic f_in_ready;
    logic f_out_valid;
    logic f_out_ready;
    logic [FW-1:0] f_out;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Wrapping column step
    function automatic logic [COL_W-1:0] next_col(input logic [COL_W-1:0] c,
                                                  input logic l8);
        logic [COL_W-1:0] nc;
        nc = c;
        if (l8) begin
            nc[2:0] = c[2:0] + 3'h1;
        end else begin
            nc[1:0] = c[1:0] + 2'h1;
        end
        return nc;
    endfunction: next_col

    function automatic logic [2:0] last_idx(input logic l8);
        return l8 ? 3'(LEN8 - 1) : 3'(LEN4 - 1);
    endfunction: last_idx

    function automatic logic [MA_W-1:0] mem_addr(input logic b, input logic [ROW_W-1:0] r,
                                                 input logic [COL_W-1:0] c);
        return {b, r, c};
    endfunction: mem_addr

    // Even bytes follow the lower gate
    function automatic logic [LANES-1:0] keep_lanes(input logic lo, input logic up);
        logic [LANES-1:0] k;
        k = '0;
        for (int b = 0; b < LANES; b++) begin
            k[b] = (b % 2 == 1) ? !up : !lo;
        end
        return k;
    endfunction: keep_lanes

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    // Resumes on second edge
    // Held while last sampled enable was low
    assign hold = !s.cke_q;
    assign cmd = {ras_n, cas_n, we_n};
    assign cmd_ok = !hold && !cs_n;
    assign bank_idx = !addr[BANK_BIT];
    assign rd_go = cmd_ok && cmd == CMD_READ;
    assign wr_go = cmd_ok && cmd == CMD_WRITE;
    assign act_go = cmd_ok && cmd == CMD_ACTIVATE;
    assign pre_go = cmd_ok && cmd == CMD_PRECHARGE;
    assign ref_go = cmd_ok && cmd == CMD_REFRESH;
    assign mode_go = cmd_ok && cmd == CMD_MODE;

    assign mode_ok = (addr[MODE_LEN_LSB+:3] == LEN4_CODE || addr[MODE_LEN_LSB+:3] == LEN8_CODE)
        && !addr[BURST_TYPE_BIT] && addr[MODE_LAT_LSB+:3] == LAT2_CODE
        && addr[MODE_ZERO_LSB+:2] == 2'h0;

    // Row of an open bank is assumed
    assign rd_word = array[mem_addr(s.rd_bank, s.row[s.rd_bank], s.rd_col)];
    // Gates act in the same cycle
    assign push_keep = keep_lanes(lower_byte_gate, upper_byte_gate);

    always_comb begin
        n = s;
        push_v = 1'b0;
        push_bank = s.wr_bank;
        push_col = s.wr_col;
        n.cke_q = cke;
        n.room = f_in_ready;
        if (!hold) begin
            n.oe = s.rd_act;
            if (s.rd_act) begin
                n.dq = rd_word;
                n.rd_col = next_col(s.rd_col, s.len8);
                n.rd_cnt = s.rd_cnt - 3'h1;
                if (s.rd_cnt == 3'h0) begin
                    n.rd_act = 1'b0;
                    if (s.rd_close) begin
                        n.open[s.rd_bank] = 1'b0;
                    end
                end
            end
            if (s.wr_act) begin
                push_v = 1'b1;
                n.wr_col = next_col(s.wr_col, s.len8);
                n.wr_cnt = s.wr_cnt - 3'h1;
                if (s.wr_cnt == 3'h0) begin
                    n.wr_act = 1'b0;
                    if (s.wr_close) begin
                        n.open[s.wr_bank] = 1'b0;
                    end
                end
            end
            // Bursts above run whatever select does
            if (cmd_ok) begin
                unique case (cmd)
                    CMD_ACTIVATE: begin
                        n.open[bank_idx] = 1'b1;
                        n.row[bank_idx] = addr[ROW_W-1:0];
                    end
                    CMD_READ: begin
                        // New read replaces a running burst
                        push_v = 1'b0;
                        n.wr_act = 1'b0;
                        n.rd_act = 1'b1;
                        n.rd_bank = bank_idx;
                        n.rd_col = addr[COL_W-1:0];
                        n.rd_cnt = last_idx(s.len8);
                        n.rd_close = addr[CLOSE_BIT];
                    end
                    CMD_WRITE: begin
                        // First word on the command edge
                        push_v = 1'b1;
                        push_bank = bank_idx;
                        push_col = addr[COL_W-1:0];
                        n.rd_act = 1'b0;
                        // Bit 9 zero gives a full burst
                        n.wr_act = !s.wr_single;
                        n.wr_bank = bank_idx;
                        n.wr_col = next_col(addr[COL_W-1:0], s.len8);
                        n.wr_cnt = last_idx(s.len8) - 3'h1;
                        n.wr_close = addr[CLOSE_BIT];
                        if (s.wr_single && addr[CLOSE_BIT]) begin
                            n.open[bank_idx] = 1'b0;
                        end
                    end
                    CMD_STOP: begin
                        n.rd_act = 1'b0;
                        n.wr_act = 1'b0;
                    end
                    CMD_PRECHARGE: begin
                        if (addr[CLOSE_BIT]) begin
                            n.open = 2'h0;
                        end else begin
                            n.open[bank_idx] = 1'b0;
                        end
                    end
                    CMD_REFRESH: begin
                        // Step row counter, banks end closed
                        n.ref_row = s.ref_row + 12'h001;
                        n.open = 2'h0;
                    end
                    CMD_MODE: begin
                        if (mode_ok) begin
                            n.len8 = addr[MODE_LEN_LSB+:3] == LEN8_CODE;
                            n.wr_single = addr[WR_SINGLE_BIT];
                        end
                    end
                    CMD_NOP: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.cke_q <= RST_CKE_Q;
            s.len8 <= RST_LEN8;
            s.room <= RST_ROOM;
        end else begin
            s <= n;
        end
    end

    // ----------------------------------------
    // Write buffer and array
    // ----------------------------------------
    // Reads own the array port; a full buffer drops words, watch write_room
    assign f_out_ready = s.cke_q && !s.rd_act;

    sdc_fifo #(.W(FW), .DEPTH(BUF_DEPTH)) u_wbuf (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(push_v),
        .in_ready(f_in_ready),
        .in_data({mem_addr(push_bank, s.row[push_bank], push_col), dq_in, push_keep}),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out)
    );

    // Only kept bytes reach the array
    always_ff @(posedge sys_clk) begin
        if (f_out_valid && f_out_ready) begin
            for (int b = 0; b < LANES; b++) begin
                if (f_out[b]) begin
                    array[f_out[FW-1-:MA_W]][b*8+:8] <= f_out[LANES+b*8+:8];
                end
            end
        end
    end

    assign dq_out = s.dq;
    assign dq_oe = s.oe;
    assign bank_open = s.open;
    assign refresh_row = s.ref_row;
    assign write_room = s.room;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_read_latency: assert property (rd_go && cke |-> ##2 s.oe)
        else $error("read data not driven two cycles after read");
    a_read_float: assert property (!s.rd_act && s.cke_q |=> !s.oe)
        else $error("outputs driven with no read burst");
    a_burst_len: assert property (rd_go |=> s.rd_cnt == last_idx(s.len8))
        else $error("burst count does not match mode");
    a_col_wrap: assert property (s.rd_act && s.cke_q && !rd_go && s.len8 |=>
        s.rd_col[COL_W-1:3] == $past(s.rd_col[COL_W-1:3])
        && s.rd_col[2:0] == $past(s.rd_col[2:0]) + 3'h1)
        else $error("column step left its block");
    a_write_now: assert property (wr_go |-> push_v && push_col == addr[COL_W-1:0])
        else $error("first write word not taken on command edge");
    a_byte_gate: assert property (push_v && lower_byte_gate && !upper_byte_gate |->
        !push_keep[0] && push_keep[1] && !push_keep[LANES-2])
        else $error("byte gate reached the wrong lanes");
    a_bus_freeze: assert property (!s.cke_q |=> $stable(s.dq) && $stable(s.oe)
        && $stable(s.rd_col))
        else $error("bus moved while suspended");
    a_resume_step: assert property (s.rd_act && s.cke_q && !$past(s.cke_q) && !rd_go
        && s.rd_cnt != 3'h0 |=> s.rd_col != $past(s.rd_col))
        else $error("burst did not resume on second edge");
    a_deselect: assert property (cs_n |=> $stable(s.len8) && $stable(s.ref_row))
        else $error("command taken while deselected");
    a_burst_on: assert property (cs_n && s.cke_q && s.rd_act && s.rd_cnt != 3'h0
        |=> s.rd_act && s.oe)
        else $error("deselect broke a burst");
    a_close_all: assert property (pre_go && addr[CLOSE_BIT] |=> s.open == 2'h0)
        else $error("precharge all left a bank open");
    a_auto_close: assert property (s.rd_act && s.rd_close && s.rd_cnt == 3'h0
        && s.cke_q && !act_go |=> !s.open[$past(s.rd_bank)])
        else $error("auto close did not close the bank");
    a_mode_keep: assert property (mode_go && !mode_ok |=> $stable(s.len8))
        else $error("invalid mode word changed the mode");
    a_first_bank: assert property (act_go && addr[BANK_BIT] |=> s.open[0])
        else $error("bank bit high did not open first bank");
    a_ref_step: assert property (ref_go |=> s.ref_row == $past(s.ref_row) + 12'h001)
        else $error("refresh row did not step");

    c_read_burst: cover property (rd_go ##1 s.rd_act [*3] ##1 s.oe);
    c_write_burst: cover property (wr_go ##1 s.wr_act [*2]);
    c_hold_read: cover property (s.rd_act && !cke ##1 !s.cke_q);
    c_mode_len8: cover property (mode_go && mode_ok && addr[2:0] == LEN8_CODE);

endmodule: sdc_core

`default_nettype wire

// [common/sdc_pkg.sv]
// Shared constants for the SDRAM command and data block
`default_nettype none

package sdc_pkg;

    // ----------------------------------------
    // Widths and depths
    // ----------------------------------------
    localparam int DQ_W = 96;
    localparam int ROW_W = 11;
    localparam int COL_W = 8;
    localparam int ADDR_W = 12;
    localparam int BUF_DEPTH = 8;
    localparam int REF_W = 12;

    // ----------------------------------------
    // Command codes as {ras_n, cas_n, we_n}
    // ----------------------------------------
    localparam logic [2:0] CMD_MODE = 3'h0;
    localparam logic [2:0] CMD_REFRESH = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_ACTIVATE = 3'h3;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_STOP = 3'h6;
    localparam logic [2:0] CMD_NOP = 3'h7;

    // ----------------------------------------
    // Address bit positions and mode fields
    // ----------------------------------------
    localparam int BANK_BIT = 11;
    localparam int CLOSE_BIT = 10;
    localparam int WR_SINGLE_BIT = 9;
    localparam int MODE_ZERO_LSB = 7;
    localparam int MODE_LAT_LSB = 4;
    localparam int BURST_TYPE_BIT = 3;
    localparam int MODE_LEN_LSB = 0;
    localparam logic [2:0] LEN4_CODE = 3'h2;
    localparam logic [2:0] LEN8_CODE = 3'h3;
    localparam logic [2:0] LAT2_CODE = 3'h2;
    localparam int LEN4 = 4;
    localparam int LEN8 = 8;

    // ----------------------------------------
    // Values after reset
    // ----------------------------------------
    localparam logic RST_CKE_Q = 1'h1;
    localparam logic RST_LEN8 = 1'h0;
    localparam logic RST_ROOM = 1'h1;

endpackage: sdc_pkg

`default_nettype wire

// [tb/sdc_ctl_model.sv]
// Controller-side model driving command, gate and write-data pins
`default_nettype none

module sdc_ctl_model (
    input wire logic sys_clk,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [sdc_pkg::ADDR_W-1:0] addr,
    output logic lower_byte_gate,
    output logic upper_byte_gate,
    output logic [sdc_pkg::DQ_W-1:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import sdc_pkg::*;

    initial begin
        cke = 1'h1;
        cs_n = 1'h1;
        {ras_n, cas_n, we_n} = CMD_NOP;
        addr = 12'h000;
        lower_byte_gate = 1'h0;
        upper_byte_gate = 1'h0;
        dq_in = '0;
    end

    // ----------------------------------------
    // Pin driver
    // ----------------------------------------
    // Encoded pins, one edge each
    task automatic drv(input logic ck, input logic cs, input logic [2:0] c,
            input logic [ADDR_W-1:0] a, input logic lo, input logic up,
            input logic dv, input logic [DQ_W-1:0] d);
        @(posedge sys_clk);
        cke <= ck;
        cs_n <= cs;
        {ras_n, cas_n, we_n} <= c;
        addr <= a;
        lower_byte_gate <= lo;
        upper_byte_gate <= up;
        // Idle bus shows the inverse, so stale words never match
        dq_in <= dv ? d : ~dq_in;
    endtask: drv
endmodule: sdc_ctl_model

`default_nettype wire

// [tb/sdc_core_bench.sv]
// Self-checking bench for the SDRAM command and data block
`default_nettype none

module sdc_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import sdc_pkg::*;

    logic sys_clk, rst, cke, cs_n, ras_n, cas_n, we_n, lo_g, up_g, dq_oe, write_room;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] dq_in, dq_out;
    logic [1:0] bank_open;
    logic [REF_W-1:0] refresh_row;
    logic [DQ_W-1:0] e [0:7];
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;

    sdc_core dut (.sys_clk(sys_clk), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .addr(addr), .lower_byte_gate(lo_g),
        .upper_byte_gate(up_g), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .bank_open(bank_open), .refresh_row(refresh_row), .write_room(write_room));
    sdc_ctl_model m (.sys_clk(sys_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .addr(addr), .lower_byte_gate(lo_g),
        .upper_byte_gate(up_g), .dq_in(dq_in));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [DQ_W-1:0] s, input logic [DQ_W-1:0] x);
        compares++;
        if (s !== x) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, x, s);
        end
    endtask: chk

    task automatic conclude();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask: conclude

    // Outputs are looked at 1 ns after the edge, once they have settled
    task automatic step(input logic [2:0] c, input logic [ADDR_W-1:0] a,
            input logic cs = 1'h0, input logic ck = 1'h1, input logic lo = 1'h0,
            input logic up = 1'h0, input logic dv = 1'h0, input logic [DQ_W-1:0] d = '0);
        m.drv(ck, cs, c, a, lo, up, dv, d);
        #1;
    endtask: step

    task automatic cmd(input logic [2:0] c, input logic [ADDR_W-1:0] a);
        step(c, a);
        step(CMD_NOP, a);
    endtask: cmd

    function automatic int col(input int s, input int l, input int i);
        return (s & ~(l - 1)) | ((s + i) & (l - 1));
    endfunction: col

    // Even bytes on the lower gate, odd on the upper
    function automatic logic [DQ_W-1:0] mrg(input logic [DQ_W-1:0] o,
            input logic [DQ_W-1:0] n, input logic lo, input logic up);
        logic [DQ_W-1:0] r;
        r = n;
        for (int b = 0; b < DQ_W / 8; b++) begin
            if (b % 2 == 0 ? lo : up) begin
                r[b*8 +: 8] = o[b*8 +: 8];
            end
        end
        return r;
    endfunction: mrg

    // Burst write, word 0 on the command edge
    task automatic wr(input logic [ADDR_W-1:0] a, input int l, input logic [7:0] sd,
            input logic [7:0] lm, input logic [7:0] um);
        logic [DQ_W-1:0] d;
        for (int i = 0; i < l; i++) begin
            d = {12{sd + 8'(i)}};
            step(i == 0 ? CMD_WRITE : CMD_NOP, a, 1'h0, 1'h1, lm[i], um[i], 1'h1, d);
            e[col(a[2:0], l, i)] = mrg(e[col(a[2:0], l, i)], d, lm[i], um[i]);
        end
        // Buffered words need idle cycles before a read sees them
        repeat (3) step(CMD_NOP, a);
    endtask: wr

    // Read burst; ds mutes the chip with read strobes up
    task automatic rd(input logic [ADDR_W-1:0] a, input int l, input logic ds);
        step(CMD_READ, a);
        step(CMD_NOP, a);
        for (int i = 0; i < l; i++) begin
            step(ds ? CMD_READ : CMD_NOP, a, ds);
            chk("dq_oe", dq_oe, 1'h1);
            chk("dq_out", dq_out, e[col(a[2:0], l, i)]);
        end
        step(CMD_NOP, a);
        chk("dq_oe_end", dq_oe, 1'h0);
    endtask: rd

    // ----------------------------------------
    // Clock, timeout and sequence
    // ----------------------------------------
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            conclude();
        end
    end

    initial begin
        rst = 1'h1;
        repeat (10) @(posedge sys_clk);
        rst <= 1'h0;
        #1;
        chk("reset", {dq_oe, bank_open, refresh_row, write_room}, 16'h0001);
        cmd(CMD_ACTIVATE, 12'h805);
        chk("bank_open", bank_open, 2'h1);
        cmd(CMD_ACTIVATE, 12'h005);
        chk("bank_open", bank_open, 2'h3);
        wr(12'h800, 4, 8'h10, 8'h00, 8'h00);
        rd(12'h800, 4, 1'h0);
        // Gated bytes, then a read while deselected
        wr(12'h801, 4, 8'h20, 8'h01, 8'h04);
        rd(12'h802, 4, 1'h1);
        // Second bank read two edges after the first, no gap between them
        wr(12'h004, 4, 8'h40, 8'h00, 8'h00);
        step(CMD_READ, 12'h800);
        step(CMD_NOP, 12'h800);
        step(CMD_READ, 12'h004);
        for (int i = 0; i < 6; i++) begin
            chk("gapless", dq_out, e[i < 2 ? i : i + 2]);
            step(CMD_NOP, 12'h000);
        end
        chk("dq_oe_end", dq_oe, 1'h0);
        step(CMD_READ, 12'h800);
        step(CMD_NOP, 12'h800);
        for (int i = 0; i < 6; i++) begin
            step(CMD_NOP, 12'h800, 1'h0, i > 1);
            chk("held", dq_out, e[i < 1 ? 0 : (i < 4 ? 1 : i - 2)]);
        end
        step(CMD_NOP, 12'h800);
        chk("dq_oe_end", dq_oe, 1'h0);
        cmd(CMD_PRECHARGE, 12'h800);
        chk("bank_open", bank_open, 2'h2);
        cmd(CMD_PRECHARGE, 12'h400);
        chk("bank_open", bank_open, 2'h0);
        cmd(CMD_REFRESH, 12'h000);
        cmd(CMD_REFRESH, 12'h000);
        chk("refresh_row", refresh_row, 12'h002);
        // Length 8, then a word with bit 7 set
        cmd(CMD_MODE, 12'h023);
        cmd(CMD_MODE, 12'h0a2);
        cmd(CMD_ACTIVATE, 12'h805);
        wr(12'h805, 8, 8'h30, 8'h08, 8'h10);
        rd(12'h803, 8, 1'h0);
        rd(12'hc02, 8, 1'h0);
        repeat (2) step(CMD_NOP, 12'h000);
        chk("auto_close", bank_open, 2'h0);
        chk("write_room", write_room, 1'h1);
        // Bit 9 set: one word per write, rest of the block untouched
        cmd(CMD_MODE, 12'h223);
        cmd(CMD_ACTIVATE, 12'h805);
        wr(12'h805, 1, 8'h50, 8'h00, 8'h00);
        rd(12'h805, 8, 1'h0);
        conclude();
    end
endmodule: sdc_core_bench

`default_nettype wire
